/* hdl/aovc_pkg.sv */
// package: constants, types and range table of the value codec
package aovc_pkg;
  localparam int NCH = 4;                // output channels
  localparam int EVW = 2 * NCH;          // event bits
  // register byte offsets
  localparam logic [7:0] OFS_WORD0 = 8'h00; // channel words, 4 apart
  localparam logic [7:0] OFS_FUNC  = 8'h10; // function codes
  localparam logic [7:0] OFS_ISTAT = 8'h14; // sticky event status
  localparam logic [7:0] OFS_IEN   = 8'h18; // interrupt enable
  localparam logic [7:0] OFS_ICLR  = 8'h1c; // status clear, write only
  localparam logic [7:0] OFS_ECHO0 = 8'h20; // returned words, 4 apart
  localparam logic [7:0] OFS_FLAGS = 8'h30; // live channel flags
  // field positions
  localparam int FLG_OVF_POS = 0;        // overflow per channel
  localparam int FLG_ERR_POS = 4;        // error per channel
  localparam int FLG_ACT_POS = 8;        // channel active
  localparam int EVT_ERR_POS = 4;        // error events in status
  localparam int SM_OVF_BIT  = 0;        // overflow bit of word
  localparam int SM_ERR_BIT  = 1;        // error bit of word
  localparam int SM_ACT_BIT  = 2;        // activity bit of word
  localparam int SM_SIGN_BIT = 15;       // sign bit of word
  localparam int SCALE_SH    = 16;       // fraction bits of gain
  // values after reset
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0]  FUNC_RST = 8'h00;
  localparam logic [7:0]  IEN_RST  = 8'h00;
  // function codes
  localparam logic [7:0] FN_NONE    = 8'h00;
  localparam logic [7:0] FN_V10_SM  = 8'h01;
  localparam logic [7:0] FN_V15_SM  = 8'h02;
  localparam logic [7:0] FN_I20B_SM = 8'h03;
  localparam logic [7:0] FN_I420_SM = 8'h04;
  localparam logic [7:0] FN_V010_SM = 8'h05;
  localparam logic [7:0] FN_I020_SM = 8'h06;
  localparam logic [7:0] FN_V10_TC  = 8'h09;
  localparam logic [7:0] FN_V15_TC  = 8'h0a;
  localparam logic [7:0] FN_I20B_TC = 8'h0b;
  localparam logic [7:0] FN_I420_TC = 8'h0c;
  localparam logic [7:0] FN_V010_TC = 8'h0d;
  localparam logic [7:0] FN_I020_TC = 8'h0e;
  // word limits
  localparam int SM_FULL     = 16384;    // rated sign-magnitude end
  localparam int SM_OVR      = 20480;    // sign-magnitude over-range
  localparam int SM_LIVE_UND = -4096;    // live zero under-range
  localparam int TC_FULL     = 27648;    // rated two's complement end
  localparam int TC_OVR      = 32767;    // two's complement limit
  localparam int TC_420_UND  = -5530;    // 4-20 mA lower limit
  localparam int TC_15_UND   = -6912;    // 1-5 V lower limit
  // set-point spans and offsets, in uA or mV
  localparam int SPAN_20MA = 20000;
  localparam int SPAN_16MA = 16000;
  localparam int SPAN_10V  = 10000;
  localparam int SPAN_4V   = 4000;
  localparam int OFS_4MA   = 4000;
  localparam int OFS_1V    = 1000;
  // gains with SCALE_SH fraction bits
  localparam int MUL_SM_20 = SPAN_20MA * (2**SCALE_SH) / SM_FULL;
  localparam int MUL_SM_16 = SPAN_16MA * (2**SCALE_SH) / SM_FULL;
  localparam int MUL_SM_10 = SPAN_10V * (2**SCALE_SH) / SM_FULL;
  localparam int MUL_SM_4  = SPAN_4V * (2**SCALE_SH) / SM_FULL;
  localparam int MUL_TC_20 = SPAN_20MA * (2**SCALE_SH) / TC_FULL;
  localparam int MUL_TC_16 = SPAN_16MA * (2**SCALE_SH) / TC_FULL;
  localparam int MUL_TC_10 = SPAN_10V * (2**SCALE_SH) / TC_FULL;
  localparam int MUL_TC_4  = SPAN_4V * (2**SCALE_SH) / TC_FULL;

  // one output range
  typedef struct packed {
    logic               valid;  // code assigned to a range
    logic               twos;   // two's complement word
    logic               isCur;  // current range
    logic signed [16:0] lo;     // under-range limit
    logic signed [16:0] hi;     // over-range limit
    logic signed [15:0] off;    // set-point at word zero
    logic [17:0]        mul;    // gain
  } aovc_range_t;

  // set-point handed to the drive stage
  typedef struct packed {
    logic               active;    // channel drives
    logic               isCurrent; // level in uA, else mV
    logic signed [15:0] level;     // set-point
  } aovc_chan_t;

  // build one table entry
  function automatic aovc_range_t aovc_mk(input int tw, input int cur,
      input int lo, input int hi, input int off, input int mul);
    aovc_range_t r;
    r.valid = 1'b1;
    r.twos  = 1'(tw);
    r.isCur = 1'(cur);
    r.lo    = 17'(lo);
    r.hi    = 17'(hi);
    r.off   = 16'(off);
    r.mul   = 18'(mul);
    return r;
  endfunction : aovc_mk

  // range table by function code
  function automatic aovc_range_t aovc_range_of(input logic [7:0] fn);
    aovc_range_t r;
    r = '0;
    case (fn)
      FN_V10_SM:  r = aovc_mk(0, 0, -SM_OVR, SM_OVR, 0, MUL_SM_10);
      FN_V15_SM:  r = aovc_mk(0, 0, SM_LIVE_UND, SM_OVR, OFS_1V, MUL_SM_4);
      FN_I20B_SM: r = aovc_mk(0, 1, -SM_OVR, SM_OVR, 0, MUL_SM_20);
      FN_I420_SM: r = aovc_mk(0, 1, SM_LIVE_UND, SM_OVR,
                              OFS_4MA, MUL_SM_16);
      FN_V010_SM: r = aovc_mk(0, 0, 0, SM_OVR, 0, MUL_SM_10);
      FN_I020_SM: r = aovc_mk(0, 1, 0, SM_OVR, 0, MUL_SM_20);
      FN_V10_TC:  r = aovc_mk(1, 0, -TC_OVR, TC_OVR, 0, MUL_TC_10);
      FN_V15_TC:  r = aovc_mk(1, 0, TC_15_UND, TC_OVR, OFS_1V, MUL_TC_4);
      FN_I20B_TC: r = aovc_mk(1, 1, -TC_OVR, TC_OVR, 0, MUL_TC_20);
      FN_I420_TC: r = aovc_mk(1, 1, TC_420_UND, TC_OVR,
                              OFS_4MA, MUL_TC_16);
      FN_V010_TC: r = aovc_mk(1, 0, 0, TC_OVR, 0, MUL_TC_10);
      FN_I020_TC: r = aovc_mk(1, 1, 0, TC_OVR, 0, MUL_TC_20);
      default:    r = '0;
    endcase
    return r;
  endfunction : aovc_range_of
endpackage : aovc_pkg

/* hdl/aovc_channel.sv */
// one channel: word decode, clamp, scaling and returned word
`timescale 1ns/1ps
module aovc_channel
  import aovc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [15:0] word,
  input  wire logic [7:0]  func,
  input  wire logic        fault,
  output aovc_chan_t       chan,
  output logic             overflow,
  output logic             errorFlag,
  output logic [15:0]      echo
);
  aovc_range_t        rng;        // selected range
  logic signed [16:0] mag;        // magnitude field as value
  logic signed [16:0] value;      // decoded word
  logic signed [16:0] clamped;    // word held inside limits
  logic signed [16:0] absVal;     // magnitude of clamped word
  logic               over;       // word beyond a limit
  logic signed [35:0] prod;       // scaled product
  logic signed [15:0] next_level; // set-point
  logic [15:0]        next_echo;  // returned word

  // range lookup, unknown codes give an invalid entry
  always_comb rng = aovc_range_of(func);

  // decode either word format
  always_comb
  begin
    mag = signed'({2'b00, word[14:3], 3'b000});
    if (rng.twos)
      value = 17'(signed'(word));
    else if (word[SM_SIGN_BIT])
      value = -mag;
    else
      value = mag;
  end

  // saturate to the range limits
  always_comb
  begin
    over    = 1'b0;
    clamped = value;
    if (value > rng.hi)
    begin
      clamped = rng.hi;
      over    = 1'b1;
    end
    else if (value < rng.lo)
    begin
      clamped = rng.lo;
      over    = 1'b1;
    end
  end

  // linear scaling: offset plus word times gain
  always_comb
  begin
    prod       = clamped * signed'({1'b0, rng.mul});
    next_level = rng.off + signed'(prod[SCALE_SH+15:SCALE_SH]);
    absVal     = clamped[16] ? -clamped : clamped;
    if (rng.twos)
      next_echo = clamped[15:0];
    else
      next_echo = {clamped[16], absVal[14:3], 1'b0, fault, over};
  end

  // registered outputs, idle when the code is not assigned
  always_ff @(posedge clock)
  begin
    if (reset || !rng.valid)
    begin
      chan      <= '0;
      overflow  <= 1'b0;
      errorFlag <= 1'b0;
      echo      <= WORD_RST;
    end
    else
    begin
      chan      <= '{active: 1'b1, isCurrent: rng.isCur, level: next_level};
      overflow  <= over;
      errorFlag <= fault;
      echo      <= next_echo;
    end
  end
endmodule : aovc_channel

/* hdl/aovc_value_codec.sv */
// apb register file, four channel codecs and event interrupt
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module aovc_value_codec
  import aovc_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NCH-1:0]   fault,
  output aovc_chan_t [NCH-1:0]  chanOut,
  output logic                  irq
);
  // register file
  logic [15:0]      chanWord [NCH];  // channel words
  logic [7:0]       funcCode [NCH];  // function codes
  logic [EVW-1:0]   irqStatus;       // sticky events
  logic [EVW-1:0]   irqEnable;       // interrupt mask
  // channel results
  logic [NCH-1:0]   ovf;             // overflow per channel
  logic [NCH-1:0]   err;             // error per channel
  logic [NCH-1:0]   ovfPrev;         // overflow last cycle
  logic [NCH-1:0]   errPrev;         // error last cycle
  logic [15:0]      echo [NCH];      // returned words
  // bus side
  logic             setup;           // first cycle of a transfer
  logic             wrAcc;           // write access phase
  logic [EVW-1:0]   clrBits;         // status bits to clear
  logic [EVW-1:0]   newEvent;        // rising flags
  logic [31:0]      rdMux;           // read data of the address
  logic             rdErr;           // address not mapped
  logic             errQ;            // held error answer
  logic [NCH-1:0]   active;          // channels that drive

  // true when a lies in a block of four words at base
  function automatic logic in_block(input logic [7:0] a,
                                    input logic [7:0] base);
    return (a[7:4] == base[7:4]) && (a[1:0] == 2'b00);
  endfunction : in_block

  // true for every mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    return in_block(a, OFS_WORD0) || in_block(a, OFS_ECHO0) ||
           a == OFS_FUNC || a == OFS_ISTAT || a == OFS_IEN ||
           a == OFS_ICLR || a == OFS_FLAGS;
  endfunction : is_mapped

  // transfer phases, no wait states in the access phase
  assign setup   = psel && !penable;
  assign wrAcc   = psel && penable && pwrite;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && errQ;

  // channel words written by the controller
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      for (int i = 0; i < NCH; i++)
        chanWord[i] <= WORD_RST;
    end
    else if (wrAcc && in_block(paddr, OFS_WORD0))
    begin
      chanWord[paddr[3:2]] <= pwdata[15:0];
    end
  end

  // function codes, one byte per channel
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      for (int i = 0; i < NCH; i++)
        funcCode[i] <= FUNC_RST;
    end
    else if (wrAcc && paddr == OFS_FUNC)
    begin
      for (int i = 0; i < NCH; i++)
        funcCode[i] <= pwdata[8*i +: 8];
    end
  end

  // interrupt enable
  always_ff @(posedge clock)
  begin
    if (reset)
      irqEnable <= IEN_RST;
    else if (wrAcc && paddr == OFS_IEN)
      irqEnable <= pwdata[EVW-1:0];
  end

  // clear strobe from the write-only clear register
  always_comb
  begin
    if (wrAcc && paddr == OFS_ICLR)
      clrBits = pwdata[EVW-1:0];
    else
      clrBits = '0;
  end

  // codec per channel
  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    aovc_channel u_chan (
      .clock     (clock),
      .reset     (reset),
      .word      (chanWord[c]),
      .func      (funcCode[c]),
      .fault     (fault[c]),
      .chan      (chanOut[c]),
      .overflow  (ovf[c]),
      .errorFlag (err[c]),
      .echo      (echo[c])
    );
    assign active[c] = chanOut[c].active;
  end

  // previous flags for edge detection
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ovfPrev <= '0;
      errPrev <= '0;
    end
    else
    begin
      ovfPrev <= ovf;
      errPrev <= err;
    end
  end

  // rising overflow and error make events
  assign newEvent = {err & ~errPrev, ovf & ~ovfPrev};

  // sticky status, a new event beats a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (reset)
      irqStatus <= '0;
    else
      irqStatus <= (irqStatus & ~clrBits) | newEvent;
  end

  // level interrupt
  assign irq = |(irqStatus & irqEnable);

  // read multiplexer
  always_comb
  begin
    rdMux = '0;
    rdErr = !is_mapped(paddr);
    if (in_block(paddr, OFS_WORD0))
      rdMux[15:0] = chanWord[paddr[3:2]];
    else if (in_block(paddr, OFS_ECHO0))
      rdMux[15:0] = echo[paddr[3:2]];
    else if (paddr == OFS_FUNC)
    begin
      for (int i = 0; i < NCH; i++)
        rdMux[8*i +: 8] = funcCode[i];
    end
    else if (paddr == OFS_ISTAT)
      rdMux[EVW-1:0] = irqStatus;
    else if (paddr == OFS_IEN)
      rdMux[EVW-1:0] = irqEnable;
    else if (paddr == OFS_FLAGS)
    begin
      rdMux[FLG_OVF_POS +: NCH] = ovf;
      rdMux[FLG_ERR_POS +: NCH] = err;
      rdMux[FLG_ACT_POS +: NCH] = active;
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prdata <= '0;
      errQ   <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? '0 : rdMux;
      errQ   <= rdErr;
    end
  end

  // checks on channel 0
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_bip_over_clamp: assert property (
    funcCode[0] == FN_I20B_SM && chanWord[0] == 16'hfff8
    |=> chanOut[0].level == 16'(-(SPAN_20MA * SM_OVR / SM_FULL)) && ovf[0])
    else $error("bipolar current not clamped");

  a_live_under_lim: assert property (
    funcCode[0] == FN_I420_SM && chanWord[0] == 16'h9000
    |=> chanOut[0].level == 16'h0000 && !ovf[0])
    else $error("live zero lower limit wrong");

  a_uni_no_under: assert property (
    funcCode[0] == FN_I020_SM && chanWord[0][15] &&
    chanWord[0][14:3] != 12'h000
    |=> ovf[0] && chanOut[0].level == 16'h0000)
    else $error("negative 0-20 mA not clamped");

  a_tc_bip_span: assert property (
    funcCode[0] == FN_I20B_TC && chanWord[0] == 16'h6c00
    |=> !ovf[0] && chanOut[0].level > 16'(SPAN_20MA - 3) &&
        chanOut[0].level <= 16'(SPAN_20MA))
    else $error("two's complement span wrong");

  a_tc_low_limit: assert property (
    funcCode[0] == FN_I420_TC && $changed(chanWord[0]) &&
    chanWord[0] == 16'(TC_420_UND - 1)
    |=> ovf[0] ##1 $past(chanWord[0], 2) == 16'(TC_420_UND - 1))
    else $error("4-20 mA lower limit not flagged");

  a_tc_zero_floor: assert property (
    funcCode[0] == FN_I020_TC && chanWord[0][15]
    |=> ovf[0] && chanOut[0].level == 16'h0000)
    else $error("two's complement 0-20 mA underflow");

  a_echo_bits: assert property (
    active[0] && $past(funcCode[0]) == FN_I20B_SM
    |-> echo[0][SM_ACT_BIT] == 1'b0 && echo[0][SM_OVF_BIT] == ovf[0] &&
        echo[0][SM_ERR_BIT] == err[0])
    else $error("information bits wrong");

  a_volt_scale: assert property (
    funcCode[0] == FN_V10_SM && chanWord[0] == 16'hc000
    |=> chanOut[0].level == 16'(-SPAN_10V) && !chanOut[0].isCurrent)
    else $error("10 V scale wrong");

  a_idle_code: assert property (
    funcCode[0] == FN_NONE |=> !active[0] && chanOut[0].level == 16'h0000)
    else $error("idle channel drives");

  a_event_sticky: assert property (
    $rose(ovf[0]) |-> ##1 irqStatus[0] [*2])
    else $error("overflow event lost");

  c_overflow: cover property ($rose(ovf[0]));
  c_irq_raised: cover property ($rose(irq));
  c_echo_read: cover property (setup && !pwrite &&
                               in_block(paddr, OFS_ECHO0));
endmodule : aovc_value_codec

/* test/aovc_ctrl_model.sv */
// controller model: apb master writing and reading channel words
`timescale 1ns/1ps
module aovc_ctrl_model
(
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus at time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    // the answer is sampled at rising edges only
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rdata   = prdata;
    err     = pslverr;
    // released lines stop showing the old value
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~addr;
    pwdata  <= ~wdata;
  endtask : xfer
endmodule : aovc_ctrl_model

/* test/tb_analog_output_value_codec.sv */
// self-checking bench of the analog output value codec
`timescale 1ns/1ps
module tb_analog_output_value_codec
  import aovc_pkg::*;
;
  // one stimulus case: code, word, clamped value, overflow
  typedef struct {
    logic [7:0]  fn;
    logic [15:0] w;
    int          v;
    logic        ovf;
  } aovc_case_t;

  logic                clock;    // system clock
  logic                reset;    // synchronous reset
  logic                psel;     // apb select
  logic                penable;  // apb enable
  logic                pwrite;   // apb direction
  logic [7:0]          paddr;    // apb address
  logic [31:0]         pwdata;   // apb write data
  logic [31:0]         prdata;   // apb read data
  logic                pready;   // apb ready
  logic                pslverr;  // apb error
  logic [NCH-1:0]      fault;    // per-channel fault
  aovc_chan_t [NCH-1:0] chanOut; // set-points
  logic                irq;      // event interrupt
  logic [31:0]         rdat;     // last read data
  logic                rerr;     // last error response
  logic [31:0]         funcReg;  // shadow of function codes
  logic [17:0]         e;        // expected set-point
  int                  ch;       // channel under test
  int                  errTotal; // mismatches
  int                  testsRun; // comparisons
  aovc_case_t          cs;       // current case
  // cases in range, at limits and beyond them
  aovc_case_t cases [20] = '{
    '{FN_I20B_TC, 16'h6C00, 27648, 1'b0},
    '{FN_I20B_SM, 16'h4000, 16384, 1'b0},
    '{FN_I20B_SM, 16'hFFF8, -20480, 1'b1},
    '{FN_I20B_SM, 16'h5007, 20480, 1'b0},
    '{FN_I420_SM, 16'h2000, 8192, 1'b0},
    '{FN_I420_SM, 16'h9000, -4096, 1'b0},
    '{FN_I420_SM, 16'h9008, -4096, 1'b1},
    '{FN_I020_SM, 16'hA000, 0, 1'b1},
    '{FN_I020_SM, 16'h5000, 20480, 1'b0},
    '{FN_I20B_TC, 16'h8001, -32767, 1'b0},
    '{FN_I20B_TC, 16'h8000, -32767, 1'b1},
    '{FN_I420_TC, 16'hEA66, -5530, 1'b0},
    '{FN_I420_TC, 16'hEA65, -5530, 1'b1},
    '{FN_I020_TC, 16'h6C00, 27648, 1'b0},
    '{FN_I020_TC, 16'hFFFF, 0, 1'b1},
    '{FN_V10_SM, 16'hC000, -16384, 1'b0},
    '{FN_V15_SM, 16'h2000, 8192, 1'b0},
    '{FN_V10_TC, 16'h6C00, 27648, 1'b0},
    '{FN_NONE, 16'h4000, 0, 1'b0},
    '{8'h07, 16'h4000, 0, 1'b0}
  };

  // controller on the far side of the register bus
  aovc_ctrl_model ctrl
  (
    .clock   (clock),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // device under test
  aovc_value_codec dut
  (
    .clock   (clock),
    .reset   (reset),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .fault   (fault),
    .chanOut (chanOut),
    .irq     (irq)
  );

  // 100 MHz clock
  always #5 clock = ~clock;

  // compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // bus write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ctrl.xfer(1'b1, a, d, rdat, rerr);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    ctrl.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
  endtask : rd

  // program one channel and let the set-point and status settle
  task automatic setCh(input int c, input logic [7:0] fn,
                       input logic [15:0] w);
    funcReg[8*c +: 8] = fn;
    wr(OFS_FUNC, funcReg);
    wr(OFS_WORD0 + 8'(4 * c), {16'h0000, w});
    repeat (3) @(negedge clock);
  endtask : setCh

  // set-point from value, offset and gain; zero when inactive
  function automatic logic [17:0] expChan(input logic [7:0] fn,
                                          input int v);
    int s [3];
    case (fn)
      FN_V10_SM:  s = '{0, 0, MUL_SM_10};
      FN_V15_SM:  s = '{0, OFS_1V, MUL_SM_4};
      FN_I20B_SM: s = '{1, 0, MUL_SM_20};
      FN_I420_SM: s = '{1, OFS_4MA, MUL_SM_16};
      FN_I020_SM: s = '{1, 0, MUL_SM_20};
      FN_V10_TC:  s = '{0, 0, MUL_TC_10};
      FN_I20B_TC: s = '{1, 0, MUL_TC_20};
      FN_I420_TC: s = '{1, OFS_4MA, MUL_TC_16};
      FN_I020_TC: s = '{1, 0, MUL_TC_20};
      default:    return 18'h0_0000;
    endcase
    return {1'b1, s[0][0], 16'(s[1] + int'((longint'(v) * s[2]) >>> 16))};
  endfunction : expChan

  // returned word: flags and magnitude, or plain two's complement
  function automatic logic [15:0] expEcho(input logic [7:0] fn,
                                          input int v, input logic ovf);
    logic [15:0] m;
    m = 16'(v < 0 ? -v : v);
    if (fn >= FN_V10_TC)
      return 16'(v);
    return {v < 0, m[14:3], 2'b00, ovf};
  endfunction : expEcho

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // watchdog against a hung handshake
  initial
  begin
    #100_000;
    errTotal++;
    results();
  end

  // main sequence
  initial
  begin
    clock    = 1'b0;
    reset    = 1'b1;
    fault    = 4'h0;
    funcReg  = 32'h0000_0000;
    errTotal = 0;
    testsRun = 0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    // reset values, unmapped place, read-only and write-only places
    rd(OFS_FUNC);
    check("func reset", rdat, 32'(FUNC_RST));
    rd(OFS_IEN);
    check("ien reset", rdat, 32'(IEN_RST));
    rd(OFS_WORD0);
    check("word reset", rdat, 32'(WORD_RST));
    rd(8'h3C);
    check("unmapped err", 32'(rerr), 32'h0000_0001);
    check("unmapped data", rdat, 32'h0000_0000);
    rd(OFS_ICLR);
    check("clear reads", rdat, 32'h0000_0000);
    wr(OFS_FLAGS, 32'hFFFF_FFFF);
    rd(OFS_FLAGS);
    check("flags ro", rdat, 32'h0000_0000);
    // every current range beyond a limit and all but two's complement 0-20 mA at one, three voltage ranges in range, each case on every channel
    for (int k = 0; k < NCH; k++)
      for (int i = 0; i < 20; i++)
      begin
        ch = (i + k) % NCH;
        cs = cases[i];
        e  = expChan(cs.fn, cs.v);
        setCh(ch, cs.fn, cs.w);
        check("setpoint", 32'(chanOut[ch]), 32'(e));
        rd(OFS_ECHO0 + 8'(4 * ch));
        check("echo", rdat,
              32'(e[17] ? expEcho(cs.fn, cs.v, cs.ovf) : 0));
        rd(OFS_FLAGS);
        check("overflow", 32'(rdat[FLG_OVF_POS + ch]), 32'(cs.ovf));
        check("active", 32'(rdat[FLG_ACT_POS + ch]), 32'(e[17]));
      end
    // overflow event raises, masks and clears the interrupt
    wr(OFS_IEN, 32'h0000_0002);
    setCh(1, FN_I020_SM, 16'h0000);
    wr(OFS_ICLR, 32'h0000_00FF);
    setCh(1, FN_I020_SM, 16'hA000);
    check("irq raised", 32'(irq), 32'h0000_0001);
    rd(OFS_ISTAT);
    check("status", rdat, 32'h0000_0002);
    wr(OFS_IEN, 32'h0000_0000);
    @(negedge clock);
    check("irq masked", 32'(irq), 32'h0000_0000);
    wr(OFS_IEN, 32'h0000_0002);
    wr(OFS_ICLR, 32'h0000_0002);
    @(negedge clock);
    check("irq cleared", 32'(irq), 32'h0000_0000);
    // internal fault shows as the error bit of the returned word
    setCh(2, FN_I420_SM, 16'h2000);
    @(posedge clock);
    fault <= 4'b0100;
    repeat (3) @(negedge clock);
    rd(OFS_ECHO0 + 8'h08);
    check("error bit", rdat, 32'h0000_2002);
    rd(OFS_FLAGS);
    check("flags", rdat, 32'h0000_0F42);
    rd(OFS_ISTAT);
    check("error event", rdat, 32'h0000_0040);
    results();
  end
endmodule : tb_analog_output_value_codec
